// ### core/gpci_port.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module gpci_port
   import gpci_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic          reset_in,
   input  wire logic          master_clear_reset_bor_in,
   input  wire gpci_bus_req_t bus_in,
   output logic [7:0]         rdata_out,
   input  wire logic [7:0]    pin_in,
   output logic [7:0]         pin_out,
   output logic [7:0]         pin_oe_n_out,
   output logic [7:0]         pullup_on_out,
   input  wire logic          sleep_in,
   output logic               wake_out,
   output logic               irq_out,
   input  wire logic          prog_mode_in,
   input  wire logic          prog_data_in,
   input  wire logic          prog_data_drive_in,
   output logic               prog_data_out,
   output logic               prog_clock_out
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic reg_hit(input logic [8:0] addr,
                                    input logic [8:0] ofs,
                                    input logic [8:0] alt);
      reg_hit = (addr == ofs) || (addr == alt);
   endfunction : reg_hit

   logic [7:0] out_latch_reg;
   logic [7:0] dir_reg;
   logic [7:0] option_reg;
   logic [7:0] pullup_en_reg;
   logic [7:0] change_en_reg;
   logic [7:0] last_read_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] irq_status_next;
   logic [7:0] irq_mask_reg;
   logic [7:0] rdata_reg;
   logic [7:0] pin_out_reg;
   logic [7:0] pin_oe_n_reg;
   logic       ext_prev_reg;
   logic       prog_data_reg;
   logic       prog_clock_reg;

   logic       hit_port;
   logic       hit_dir;
   logic       hit_option;
   logic       hit_status;
   logic       hit_mask;
   logic       hit_pullup;
   logic       hit_change;
   logic       port_access;
   logic       mismatch;
   logic       ext_edge;
   logic [7:0] irq_set;
   logic [7:0] irq_clear;

   assign hit_port   = reg_hit(bus_in.addr, PORT_DATA_OFS,
                               PORT_DATA_ALT_OFS);
   assign hit_dir    = reg_hit(bus_in.addr, DIR_OFS, DIR_ALT_OFS);
   assign hit_option = reg_hit(bus_in.addr, OPTION_OFS, OPTION_ALT_OFS);
   assign hit_status = reg_hit(bus_in.addr, IRQ_STATUS_OFS,
                               IRQ_STATUS_OFS);
   assign hit_mask   = reg_hit(bus_in.addr, IRQ_MASK_OFS, IRQ_MASK_OFS);
   assign hit_pullup = reg_hit(bus_in.addr, PULLUP_OFS, PULLUP_OFS);
   assign hit_change = reg_hit(bus_in.addr, CHANGE_EN_OFS, CHANGE_EN_OFS);

   assign port_access = hit_port && (bus_in.rd || bus_in.wr);

   ////////////////////////////////////////////////////////////////////////////
   // Output latch. Its contents are undefined by design after power-up;
   // zero is simply what the flop holds.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         out_latch_reg <= LATCH_RESET;
      end else if (bus_in.wr && hit_port) begin
         out_latch_reg <= bus_in.wdata;
      end
   end

   // Direction and option follow every reset; the enable fields only
   // power-on reset.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         dir_reg    <= DIR_RESET;
         option_reg <= OPTION_RESET;
      end else if (master_clear_reset_bor_in) begin
         dir_reg    <= DIR_RESET;
         option_reg <= OPTION_RESET;
      end else begin
         if (bus_in.wr && hit_dir) begin
            dir_reg <= bus_in.wdata;
         end
         if (bus_in.wr && hit_option) begin
            option_reg <= bus_in.wdata;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pullup_en_reg <= PULLUP_RESET;
         change_en_reg <= CHANGE_EN_RESET;
      end else begin
         if (bus_in.wr && hit_pullup) begin
            pullup_en_reg <= bus_in.wdata;
         end
         if (bus_in.wr && hit_change) begin
            change_en_reg <= bus_in.wdata & CHANGE_USED_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Last-read latch. It ignores the master-clear input on purpose so a
   // change that arrived around that reset is still reported afterwards.
   // A write loads it too, since the core does a read-modify-write.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         last_read_reg <= LATCH_RESET;
      end else if (port_access) begin
         last_read_reg <= pin_in;
      end
   end

   // A pin that moves in the access cycle is captured into the latch, but
   // its mismatch in that cycle still sets the change flag at the same edge.
   assign mismatch = |((pin_in ^ last_read_reg) & change_en_reg
                       & CHANGE_USED_MASK);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= pin_in[EXT_IRQ_PIN];
      end
   end

   assign ext_edge = option_reg[OPT_EXT_EDGE_BIT]
                     ? (pin_in[EXT_IRQ_PIN] && !ext_prev_reg)
                     : (!pin_in[EXT_IRQ_PIN] && ext_prev_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over a write-one-to-clear in the same
   // cycle, so a lasting mismatch keeps the flag up.
   always_comb begin
      irq_set = 8'h00;
      irq_set[IRQ_CHANGE_BIT] = mismatch;
      irq_set[IRQ_EXT_BIT]    = ext_edge;
      irq_clear = (bus_in.wr && hit_status) ? bus_in.wdata : 8'h00;
      irq_status_next = ((irq_status_reg & ~irq_clear) | irq_set)
                        & IRQ_USED_MASK;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_status_reg <= IRQ_RESET;
      end else if (master_clear_reset_bor_in) begin
         irq_status_reg <= IRQ_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_mask_reg <= IRQ_RESET;
      end else if (master_clear_reset_bor_in) begin
         irq_mask_reg <= IRQ_RESET;
      end else if (bus_in.wr && hit_mask) begin
         irq_mask_reg <= bus_in.wdata & IRQ_USED_MASK;
      end
   end

   assign irq_out  = |(irq_status_reg & irq_mask_reg);
   assign wake_out = sleep_in && irq_status_reg[IRQ_CHANGE_BIT]
                     && irq_mask_reg[IRQ_CHANGE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand for exactly one cycle; unmapped reads return zero.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_reg <= READ_IDLE;
      end else if (!bus_in.rd) begin
         rdata_reg <= READ_IDLE;
      end else if (hit_port) begin
         rdata_reg <= pin_in;
      end else if (hit_dir) begin
         rdata_reg <= dir_reg;
      end else if (hit_option) begin
         rdata_reg <= option_reg;
      end else if (hit_status) begin
         rdata_reg <= irq_status_reg;
      end else if (hit_mask) begin
         rdata_reg <= irq_mask_reg;
      end else if (hit_pullup) begin
         rdata_reg <= pullup_en_reg;
      end else if (hit_change) begin
         rdata_reg <= change_en_reg;
      end else begin
         rdata_reg <= READ_IDLE;
      end
   end

   assign rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Pad drive. In programming mode the clock pin is released and the
   // data pin follows the programmer, overriding the port registers.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pin_out_reg  <= LATCH_RESET;
         pin_oe_n_reg <= DIR_RESET;
      end else begin
         pin_out_reg  <= out_latch_reg;
         pin_oe_n_reg <= dir_reg;
         if (prog_mode_in) begin
            pin_oe_n_reg[PROG_CLOCK_PIN] <= 1'b1;
            pin_oe_n_reg[PROG_DATA_PIN]  <= !prog_data_drive_in;
            pin_out_reg[PROG_DATA_PIN]   <= prog_data_in;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prog_data_reg  <= 1'b0;
         prog_clock_reg <= 1'b0;
      end else begin
         prog_data_reg  <= pin_in[PROG_DATA_PIN];
         prog_clock_reg <= pin_in[PROG_CLOCK_PIN];
      end
   end

   assign pin_out        = pin_out_reg;
   assign pin_oe_n_out   = pin_oe_n_reg;
   assign prog_data_out  = prog_data_reg;
   assign prog_clock_out = prog_clock_reg;

   // Pull-ups are cut on outputs straight from the direction register, not the
   // pad enable, so programming mode can drive the data pin against one.
   assign pullup_on_out = pullup_en_reg & dir_reg
                          & {8{!option_reg[OPT_PULLUP_DIS_BIT]}};

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   sequence s_port_access;
      port_access;
   endsequence

   sequence s_pins_quiet;
      pin_in == $past(pin_in);
   endsequence

   sequence s_mismatch_clear;
      mismatch && !master_clear_reset_bor_in && bus_in.wr && hit_status
      && bus_in.wdata[IRQ_CHANGE_BIT];
   endsequence

   a_pullup_output_off:
      assert property ((pullup_on_out & ~dir_reg) == 8'h00)
      else $error("pull-up on while pin is an output");

   a_pullup_global_off:
      assert property (option_reg[OPT_PULLUP_DIS_BIT]
                       |-> pullup_on_out == 8'h00)
      else $error("pull-up on while globally disabled");

   a_change_upper_only:
      assert property (change_en_reg[3:0] == 4'h0)
      else $error("change enable set on a lower pin");

   a_mismatch_sets_flag:
      assert property (mismatch && !master_clear_reset_bor_in
                       |=> irq_status_reg[IRQ_CHANGE_BIT])
      else $error("mismatch did not set port change flag");

   a_flag_clear_blocked:
      assert property (s_mismatch_clear
                       |=> irq_status_reg[IRQ_CHANGE_BIT])
      else $error("flag cleared during mismatch");

   a_access_ends_mismatch:
      assert property (s_port_access ##1 s_pins_quiet |-> !mismatch)
      else $error("mismatch survived port access");

   a_latch_keeps_master_clear_reset:
      assert property (master_clear_reset_bor_in && !port_access
                       |=> $stable(last_read_reg))
      else $error("last-read latch changed on master clear");

   a_flag_after_master_clear_reset:
      assert property (master_clear_reset_bor_in ##1 (mismatch && !master_clear_reset_bor_in)
                       |=> irq_status_reg[IRQ_CHANGE_BIT])
      else $error("flag not set after master clear");

   a_wake_on_change:
      assert property (mismatch && irq_mask_reg[IRQ_CHANGE_BIT]
                       && !master_clear_reset_bor_in && !(bus_in.wr && hit_mask)
                       ##1 sleep_in && !master_clear_reset_bor_in
                       |-> wake_out)
      else $error("no wake on enabled port change");

   a_read_port_pins:
      assert property (bus_in.rd && hit_port |=> rdata_out == $past(pin_in))
      else $error("port read returned wrong value");

   a_output_drive:
      assert property (!prog_mode_in |=> pin_oe_n_out == $past(dir_reg)
                       && pin_out == $past(out_latch_reg))
      else $error("pad drive does not follow direction");

   a_ext_rising_edge:
      assert property (option_reg[OPT_EXT_EDGE_BIT] && !master_clear_reset_bor_in
                       && $rose(pin_in[EXT_IRQ_PIN])
                       |=> irq_status_reg[IRQ_EXT_BIT])
      else $error("external edge not flagged");

   a_prog_clock_input:
      assert property (prog_mode_in |=> pin_oe_n_out[PROG_CLOCK_PIN])
      else $error("programming clock pin driven");

   a_port_mirror:
      assert property (bus_in.rd && bus_in.addr == PORT_DATA_ALT_OFS
                       |=> rdata_out == $past(pin_in))
      else $error("mirrored port read failed");

endmodule : gpci_port

// ### core/gpci_pkg.sv
package gpci_pkg;

   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register map; mirrored registers answer at both offsets.
   localparam logic [8:0] PORT_DATA_OFS     = 9'h006;
   localparam logic [8:0] PORT_DATA_ALT_OFS = 9'h106;
   localparam logic [8:0] DIR_OFS           = 9'h086;
   localparam logic [8:0] DIR_ALT_OFS       = 9'h186;
   localparam logic [8:0] OPTION_OFS        = 9'h081;
   localparam logic [8:0] OPTION_ALT_OFS    = 9'h181;
   localparam logic [8:0] IRQ_STATUS_OFS    = 9'h00b;
   localparam logic [8:0] IRQ_MASK_OFS      = 9'h08b;
   localparam logic [8:0] PULLUP_OFS        = 9'h095;
   localparam logic [8:0] CHANGE_EN_OFS     = 9'h096;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0] DIR_RESET       = 8'hff;
   localparam logic [7:0] OPTION_RESET    = 8'hff;
   localparam logic [7:0] PULLUP_RESET    = 8'hff;
   localparam logic [7:0] CHANGE_EN_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET       = 8'h00;
   localparam logic [7:0] LATCH_RESET     = 8'h00;
   localparam logic [7:0] READ_IDLE       = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and masks.
   localparam int         OPT_PULLUP_DIS_BIT = 7;
   localparam int         OPT_EXT_EDGE_BIT   = 6;
   localparam int         IRQ_CHANGE_BIT     = 0;
   localparam int         IRQ_EXT_BIT        = 1;
   localparam int         EXT_IRQ_PIN        = 0;
   localparam int         PROG_DATA_PIN      = 7;
   localparam int         PROG_CLOCK_PIN     = 6;
   localparam logic [7:0] IRQ_USED_MASK      = 8'h03;
   localparam logic [7:0] CHANGE_USED_MASK   = 8'hf0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } gpci_bus_req_t;

endpackage : gpci_pkg

// ### sim/gpci_pin_model.sv
`timescale 1ns/1ps
module gpci_pin_model
   import gpci_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] pad_out_in,
   input  wire logic [7:0] pad_oe_n_in,
   input  wire logic [7:0] pullup_on_in,
   input  wire logic [7:0] drive_en_in,
   input  wire logic [7:0] drive_val_in,
   output logic [7:0]      level_out
);
   logic [7:0] float_reg = 8'h00;

   // An undriven pin wanders every cycle, so a stale level never passes
   // for a real one.
   always_ff @(posedge clk_in) begin
      float_reg <= ~float_reg;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad_oe_n_in[i]) begin
            level_out[i] = pad_out_in[i];
         end else if (drive_en_in[i]) begin
            level_out[i] = drive_val_in[i];
         end else if (pullup_on_in[i]) begin
            level_out[i] = 1'b1;
         end else begin
            level_out[i] = float_reg[i];
         end
      end
   end
endmodule : gpci_pin_model

// ### sim/gpio_port_change_irq_test.sv
`timescale 1ns/1ps
module gpio_port_change_irq_test;
   import gpci_pkg::*;
   logic          clk_in      = 1'b0;
   logic          reset_in    = 1'b1;
   logic          master_clear_reset        = 1'b0;
   gpci_bus_req_t bus         = '0;
   logic [7:0]    rdata;
   logic [7:0]    lvl;
   logic [7:0]    pin_o;
   logic [7:0]    oe_n;
   logic [7:0]    pull_on;
   logic [7:0]    drv_en      = 8'h00;
   logic [7:0]    drv_val     = 8'h00;
   logic          sleep       = 1'b0;
   logic          wake;
   logic          irq;
   logic          prog_mode   = 1'b0;
   logic          prog_data   = 1'b0;
   logic          prog_drive  = 1'b0;
   logic          prog_dat_o;
   logic          prog_clk_o;
   int            errors          = 0;
   int            samples_checked = 0;
   logic [7:0]    d;

   always #12.5 clk_in = ~clk_in;

   gpci_port i_dut (.clk_in(clk_in), .reset_in(reset_in),
      .master_clear_reset_bor_in(master_clear_reset), .bus_in(bus), .rdata_out(rdata), .pin_in(lvl),
      .pin_out(pin_o), .pin_oe_n_out(oe_n), .pullup_on_out(pull_on),
      .sleep_in(sleep), .wake_out(wake), .irq_out(irq),
      .prog_mode_in(prog_mode), .prog_data_in(prog_data),
      .prog_data_drive_in(prog_drive), .prog_data_out(prog_dat_o),
      .prog_clock_out(prog_clk_o));

   gpci_pin_model i_pins (.clk_in(clk_in), .pad_out_in(pin_o),
      .pad_oe_n_in(oe_n), .pullup_on_in(pull_on), .drive_en_in(drv_en),
      .drive_val_in(drv_val), .level_out(lvl));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [7:0] s,
                        input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge clk_in);
      bus.addr  <= a;
      bus.wdata <= v;
      bus.wr    <= 1'b1;
      @(posedge clk_in);
      bus.wr <= 1'b0;
      #1;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge clk_in);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   task automatic rd_chk(input logic [8:0] a, input logic [7:0] e,
                         input string n);
      logic [7:0] v;
      rd(a, v);
      check(n, v, e);
   endtask : rd_chk

   task automatic pins(input logic [7:0] en, input logic [7:0] v);
      @(posedge clk_in);
      drv_en  <= en;
      drv_val <= v;
   endtask : pins

   task automatic pulse_master_clear_reset();
      @(posedge clk_in);
      master_clear_reset <= 1'b1;
      cyc(2);
      master_clear_reset <= 1'b0;
      cyc(2);
   endtask : pulse_master_clear_reset

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(DIR_OFS, 8'hff, "direction");
      rd_chk(OPTION_ALT_OFS, 8'hff, "option");
      rd_chk(CHANGE_EN_OFS, 8'h00, "change_en");
      rd_chk(PULLUP_OFS, 8'hff, "pullup_en");
      rd_chk(9'h1ff, 8'h00, "unmapped");
      check("pullup_on", pull_on, 8'h00);
      check("oe_n", oe_n, 8'hff);
      $display("reset test done");
   endtask : t_reset

   task automatic t_pullup();
      pins(8'h00, 8'h00);
      wr(OPTION_ALT_OFS, 8'h7f);
      check("pullup_all", pull_on, 8'hff);
      wr(PULLUP_OFS, 8'ha5);
      check("pullup_sel", pull_on, 8'ha5);
      rd(PORT_DATA_OFS, d);
      check("pulled_pins", d & 8'ha5, 8'ha5);
      wr(DIR_OFS, 8'h0f);
      check("pullup_out", pull_on, 8'h05);
      wr(OPTION_OFS, 8'hff);
      wr(DIR_OFS, 8'hff);
      check("pullup_off", pull_on, 8'h00);
      $display("pull-up test done");
   endtask : t_pullup

   task automatic t_output();
      wr(PORT_DATA_ALT_OFS, 8'h3c);
      wr(DIR_ALT_OFS, 8'h00);
      // The pad flops load on this edge, so look once they have settled.
      cyc(1);
      #1;
      check("oe_n_out", oe_n, 8'h00);
      check("pin_out", pin_o, 8'h3c);
      rd_chk(PORT_DATA_OFS, 8'h3c, "port_read");
      @(posedge clk_in);
      #1;
      check("rdata_idle", rdata, 8'h00);
      wr(DIR_OFS, 8'hff);
      cyc(1);
      #1;
      check("oe_n_in", oe_n, 8'hff);
      $display("output test done");
   endtask : t_output

   task automatic t_change();
      pins(8'hff, 8'h00);
      rd(PORT_DATA_OFS, d);
      wr(IRQ_STATUS_OFS, 8'h03);
      wr(CHANGE_EN_OFS, 8'hff);
      rd_chk(CHANGE_EN_OFS, 8'hf0, "change_en_rb");
      wr(IRQ_MASK_OFS, 8'h01);
      pins(8'hff, 8'h0e);
      cyc(2);
      rd_chk(IRQ_STATUS_OFS, 8'h00, "low_pins");
      pins(8'hff, 8'h2e);
      cyc(2);
      rd_chk(IRQ_STATUS_OFS, 8'h01, "change_flag");
      check("irq_set", {7'h00, irq}, 8'h01);
      @(posedge clk_in);
      sleep <= 1'b1;
      #1;
      check("wake", {7'h00, wake}, 8'h01);
      wr(IRQ_STATUS_OFS, 8'h01);
      rd_chk(IRQ_STATUS_OFS, 8'h01, "flag_held");
      rd(PORT_DATA_ALT_OFS, d);
      wr(IRQ_STATUS_OFS, 8'h01);
      rd_chk(IRQ_STATUS_OFS, 8'h00, "flag_cleared");
      check("irq_clear", {6'h00, wake, irq}, 8'h00);
      @(posedge clk_in);
      sleep <= 1'b0;
      pins(8'hff, 8'h3e);
      cyc(2);
      wr(PORT_DATA_OFS, 8'h00);
      wr(IRQ_STATUS_OFS, 8'h01);
      rd_chk(IRQ_STATUS_OFS, 8'h00, "write_ends");
      $display("change test done");
   endtask : t_change

   task automatic t_keep();
      pulse_master_clear_reset();
      rd_chk(IRQ_STATUS_OFS, 8'h00, "latch_kept");
      rd_chk(CHANGE_EN_OFS, 8'hf0, "enable_kept");
      pins(8'hff, 8'h1e);
      cyc(2);
      pulse_master_clear_reset();
      rd_chk(IRQ_STATUS_OFS, 8'h01, "flag_after");
      rd_chk(IRQ_MASK_OFS, 8'h00, "mask_reset");
      rd(PORT_DATA_OFS, d);
      wr(IRQ_STATUS_OFS, 8'h01);
      $display("retention test done");
   endtask : t_keep

   task automatic t_ext();
      wr(IRQ_MASK_OFS, 8'h02);
      pins(8'hff, 8'h1f);
      cyc(2);
      rd_chk(IRQ_STATUS_OFS, 8'h02, "ext_rise");
      check("ext_irq", {7'h00, irq}, 8'h01);
      wr(IRQ_STATUS_OFS, 8'h02);
      wr(OPTION_OFS, 8'hbf);
      pins(8'hff, 8'h1e);
      cyc(2);
      rd_chk(IRQ_STATUS_OFS, 8'h02, "ext_fall");
      wr(IRQ_STATUS_OFS, 8'h02);
      $display("external irq test done");
   endtask : t_ext

   task automatic t_prog();
      pins(8'h7f, 8'h40);
      @(posedge clk_in);
      prog_mode  <= 1'b1;
      prog_drive <= 1'b1;
      prog_data  <= 1'b1;
      cyc(3);
      #1;
      check("prog_pads", {5'h00, oe_n[7:6], pin_o[7]}, 8'h03);
      check("prog_outs", {6'h00, prog_dat_o, prog_clk_o}, 8'h03);
      @(posedge clk_in);
      prog_data <= 1'b0;
      cyc(3);
      #1;
      check("prog_data0", {6'h00, prog_dat_o, prog_clk_o}, 8'h01);
      $display("programming pin test done");
   endtask : t_prog

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(10);
      reset_in <= 1'b0;
      t_reset();
      t_pullup();
      t_output();
      t_change();
      t_keep();
      t_ext();
      t_prog();
      stop_test();
   end

   // The sequence is short, so a hang anywhere shows up as this limit.
   initial begin
      cyc(5000);
      errors++;
      $display("[ERR] timeout expected finish seen hang");
      stop_test();
   end
endmodule : gpio_port_change_irq_test
